// File: include/cpr_pkg.sv
// Constants for the clock, PLL and de-skew pattern configuration register bank
// Function
// - PLL register written at 08h, read back unchanged at 09h.
// - PLL bit 1 picks low bandwidth when clear, high bandwidth when set.
// - Writing one to PLL bit 0 restarts VCO calibration.
// - With PLL bit 0 clear, loss of lock starts calibration automatically.
// - Clock input register written at 0Ah, read back unchanged at 0Bh.
// - Clock bit 5 passes reference clock straight or inverted.
// - Clock bit 4 enables 100mV hysteresis for CMOS clocks.
// - Clock bit 3 enables 50mV hysteresis for CMOS clocks.
// - Clock bit 2 enables 20mV hysteresis for LVDS clocks.
// - 10mV hysteresis on by default; clock bit 1 turns it off.
// - Clock bit 0 disables every hysteresis setting.
// - Lower pattern register written at 10h, read back at 11h.
// - Lower pattern register gives pattern bits 7:0.
// - Bits 3:0 of upper pattern register at 12h give pattern bits 11:8.
// - Read of 13h returns value last written at 12h.
// - Training sequence 3 makes the serializer send the custom pattern.
package cpr_pkg;

    // Register addresses
    localparam logic [6:0] ADDR_PLL_CTRL     = 7'h08;
    localparam logic [6:0] ADDR_PLL_RB       = 7'h09;
    localparam logic [6:0] ADDR_CLK_HYST     = 7'h0a;
    localparam logic [6:0] ADDR_CLK_HYST_RB  = 7'h0b;
    localparam logic [6:0] ADDR_PAT_LOW      = 7'h10;
    localparam logic [6:0] ADDR_PAT_LOW_RB   = 7'h11;
    localparam logic [6:0] ADDR_PAT_HIGH     = 7'h12;
    localparam logic [6:0] ADDR_PAT_HIGH_RB  = 7'h13;

    // Reset value of every register
    localparam logic [7:0] REG_RESET         = 8'h00;

    // PLL register fields
    localparam int BIT_VCO_CAL_RESTART       = 0;
    localparam int BIT_PLL_HIGH_BW_SEL       = 1;

    // Clock input register fields
    localparam int BIT_ALL_HYST_DISABLE      = 0;
    localparam int BIT_DEFAULT_HYST_DISABLE  = 1;
    localparam int BIT_HYST_20MV_EN          = 2;
    localparam int BIT_HYST_50MV_EN          = 3;
    localparam int BIT_HYST_100MV_EN         = 4;
    localparam int BIT_REF_CLK_INVERT        = 5;

    // Upper pattern register holds pattern bits 11:8 in its low nibble
    localparam int PAT_HIGH_MSB              = 3;

    // Training sequence that selects the custom pattern
    localparam logic [1:0] TRAIN_SEQ_CUSTOM  = 2'h3;

    // Serial frame: one command byte (read flag, 7-bit address), one data byte
    localparam int BITS_PER_BYTE             = 8;
    localparam logic [2:0] BIT_CNT_LAST      = 3'h7;
    localparam int CMD_READ_BIT              = 7;

    // Synchroniser depth for pin inputs
    localparam int SYNC_STAGES               = 2;
    localparam int SYNC_WIDTH                = 4;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CMD,
        ST_DATA
    } cpr_state_t;

endpackage

// File: hdl/cpr_regs.sv
// Serial-port register bank for PLL, clock input and de-skew pattern setup
`timescale 1ns/1ps
module cpr_regs
    import cpr_pkg::*;
(
    // Clock, reset, enable
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    // Serial control port pins
    input  wire logic        spiCsN,
    input  wire logic        spiSclk,
    input  wire logic        spiSdi,
    output logic             spiSdo,
    output logic             spiSdoOe,
    // Analog PLL status and control
    input  wire logic        pllLocked,
    output logic             pllHighBwSel,
    output logic             vcoCalStart,
    // Clock receiver control
    output logic             refClkInvert,
    output logic             hyst100mvEn,
    output logic             hyst50mvEn,
    output logic             hyst20mvEn,
    output logic             hyst10mvEn,
    // Serializer pattern
    input  wire logic [1:0]  trainSel,
    output logic [11:0]      customPattern,
    output logic             customPatternSel
);

    // Stored registers
    logic [7:0]        pllCtrlReg;
    logic [7:0]        clkHystReg;
    logic [7:0]        patLowReg;
    logic [7:0]        patHighReg;

    // Synchronised pins
    logic [SYNC_WIDTH-1:0] syncIn;
    logic [SYNC_WIDTH-1:0] syncStage1Reg;
    logic [SYNC_WIDTH-1:0] syncStage2Reg;
    logic              csNS;
    logic              sclkS;
    logic              sdiS;
    logic              lockS;
    logic              sclkPrevReg;
    logic              lockPrevReg;
    logic              sclkRise;
    logic              sclkFall;
    logic              lockLost;

    // Serial frame state
    cpr_state_t        stateReg;
    logic [2:0]        bitCntReg;
    logic [7:0]        rxShiftReg;
    logic [7:0]        txShiftReg;
    logic [6:0]        addrReg;
    logic              readReg;
    logic [7:0]        rxByte;
    logic              byteDone;
    logic              wrStrobe;
    logic [7:0]        wrData;

    function automatic logic isAddr(input logic [6:0] a, input logic [6:0] ref_a);
        isAddr = (a == ref_a);
    endfunction

    function automatic logic [7:0] readMux(input logic [6:0] a,
                                           input logic [7:0] pll,
                                           input logic [7:0] hyst,
                                           input logic [7:0] lo,
                                           input logic [7:0] hi);
        logic [7:0] v;
        v = 8'h00;
        if (isAddr(a, ADDR_PLL_RB))
            v = pll;
        if (isAddr(a, ADDR_CLK_HYST_RB))
            v = hyst;
        if (isAddr(a, ADDR_PAT_LOW_RB))
            v = lo;
        if (isAddr(a, ADDR_PAT_HIGH_RB))
            v = hi;
        readMux = v;
    endfunction

    // Pins arrive from the host's clock domain; two flops before any use
    assign syncIn = {pllLocked, spiSdi, spiSclk, spiCsN};

    genvar g;
    generate
        for (g = 0; g < SYNC_WIDTH; g = g + 1)
        begin : gen_sync
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    // Chip select starts deselected so no frame opens at reset release
                    syncStage1Reg[g] <= (g == 0);
                    syncStage2Reg[g] <= (g == 0);
                end
                else if (ce)
                begin
                    syncStage1Reg[g] <= syncIn[g];
                    syncStage2Reg[g] <= syncStage1Reg[g];
                end
            end
        end
    endgenerate

    assign csNS  = syncStage2Reg[0];
    assign sclkS = syncStage2Reg[1];
    assign sdiS  = syncStage2Reg[2];
    assign lockS = syncStage2Reg[3];

    // Edge detectors look only at the second synchroniser stage
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sclkPrevReg <= 1'b0;
            lockPrevReg <= 1'b0;
        end
        else if (ce)
        begin
            sclkPrevReg <= sclkS;
            lockPrevReg <= lockS;
        end
    end

    assign sclkRise = sclkS & ~sclkPrevReg;
    assign sclkFall = ~sclkS & sclkPrevReg;
    assign lockLost = lockPrevReg & ~lockS;

    assign rxByte   = {rxShiftReg[6:0], sdiS};
    assign byteDone = sclkRise && (bitCntReg == BIT_CNT_LAST);

    // Frame sequencer: command byte then data byte, MSB first
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stateReg   <= ST_IDLE;
            bitCntReg  <= 3'h0;
            rxShiftReg <= 8'h00;
            addrReg    <= 7'h00;
            readReg    <= 1'b0;
        end
        else if (ce)
        begin
            if (csNS)
            begin
                // Deselect aborts any partial frame; nothing is written
                stateReg  <= ST_IDLE;
                bitCntReg <= 3'h0;
            end
            else
            begin
                case (stateReg)
                    ST_IDLE:
                    begin
                        stateReg  <= ST_CMD;
                        bitCntReg <= 3'h0;
                    end
                    ST_CMD:
                    begin
                        if (sclkRise)
                        begin
                            rxShiftReg <= rxByte;
                            bitCntReg  <= bitCntReg + 3'h1;
                        end
                        if (byteDone)
                        begin
                            readReg  <= rxByte[CMD_READ_BIT];
                            addrReg  <= rxByte[6:0];
                            stateReg <= ST_DATA;
                        end
                    end
                    ST_DATA:
                    begin
                        if (sclkRise)
                        begin
                            rxShiftReg <= rxByte;
                            bitCntReg  <= bitCntReg + 3'h1;
                        end
                        // Further write bytes in the same frame repeat the same address; further read bytes shift out zeros
                    end
                    default:
                    begin
                        stateReg <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    assign wrStrobe = ce && !csNS && (stateReg == ST_DATA) && byteDone && !readReg;
    assign wrData   = rxByte;

    // Register storage; writes to read-back or unmapped addresses are dropped
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pllCtrlReg <= REG_RESET;
            clkHystReg <= REG_RESET;
            patLowReg  <= REG_RESET;
            patHighReg <= REG_RESET;
        end
        else if (wrStrobe)
        begin
            // Reserved bits are stored as sent so read-back matches the write
            if (isAddr(addrReg, ADDR_PLL_CTRL))
                pllCtrlReg <= wrData;
            if (isAddr(addrReg, ADDR_CLK_HYST))
                clkHystReg <= wrData;
            if (isAddr(addrReg, ADDR_PAT_LOW))
                patLowReg  <= wrData;
            if (isAddr(addrReg, ADDR_PAT_HIGH))
                patHighReg <= wrData;
        end
    end

    // Read data: loaded after the command byte, shifted out on falling sclk
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            txShiftReg <= 8'h00;
            spiSdo     <= 1'b0;
            spiSdoOe   <= 1'b0;
        end
        else if (ce)
        begin
            if (csNS)
            begin
                spiSdoOe <= 1'b0;
            end
            else if (stateReg == ST_CMD && byteDone)
            begin
                txShiftReg <= readMux(rxByte[6:0], pllCtrlReg, clkHystReg,
                                      patLowReg, patHighReg);
                spiSdoOe   <= rxByte[CMD_READ_BIT];
            end
            else if (stateReg == ST_DATA && sclkFall && readReg)
            begin
                spiSdo     <= txShiftReg[BITS_PER_BYTE-1];
                txShiftReg <= {txShiftReg[6:0], 1'b0};
            end
        end
    end

    // PLL control: a manual restart pulses on the write itself; lock loss
    // only triggers when manual restart is not held, so the two never fight
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            vcoCalStart <= 1'b0;
        end
        else if (ce)
        begin
            vcoCalStart <= 1'b0;
            if (wrStrobe && isAddr(addrReg, ADDR_PLL_CTRL) && wrData[BIT_VCO_CAL_RESTART])
                vcoCalStart <= 1'b1;
            else if (lockLost && !pllCtrlReg[BIT_VCO_CAL_RESTART])
                vcoCalStart <= 1'b1;
        end
    end

    assign pllHighBwSel = pllCtrlReg[BIT_PLL_HIGH_BW_SEL];

    // Effective hysteresis enables, registered one cycle after the store
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            refClkInvert <= 1'b0;
            hyst100mvEn  <= 1'b0;
            hyst50mvEn   <= 1'b0;
            hyst20mvEn   <= 1'b0;
            hyst10mvEn   <= 1'b1;
        end
        else if (ce)
        begin
            refClkInvert <= clkHystReg[BIT_REF_CLK_INVERT];
            hyst100mvEn  <= clkHystReg[BIT_HYST_100MV_EN]
                            && !clkHystReg[BIT_ALL_HYST_DISABLE];
            hyst50mvEn   <= clkHystReg[BIT_HYST_50MV_EN]
                            && !clkHystReg[BIT_ALL_HYST_DISABLE];
            hyst20mvEn   <= clkHystReg[BIT_HYST_20MV_EN]
                            && !clkHystReg[BIT_ALL_HYST_DISABLE];
            hyst10mvEn   <= !clkHystReg[BIT_DEFAULT_HYST_DISABLE]
                            && !clkHystReg[BIT_ALL_HYST_DISABLE];
        end
    end

    // Serializer pattern selection
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            customPatternSel <= 1'b0;
        else if (ce)
            customPatternSel <= (trainSel == TRAIN_SEQ_CUSTOM);
    end

    assign customPattern = {patHighReg[PAT_HIGH_MSB:0], patLowReg};

endmodule

// File: bench/cpr_regs_checker.sv
// Port-level assertions for the configuration register bank
`timescale 1ns/1ps
module cpr_regs_checker
    import cpr_pkg::*;
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        ce,
    // Serial port
    input wire logic        spiCsN,
    input wire logic        spiSdoOe,
    // Controls
    input wire logic        pllLocked,
    input wire logic        pllHighBwSel,
    input wire logic        vcoCalStart,
    input wire logic        refClkInvert,
    input wire logic        hyst100mvEn,
    input wire logic        hyst50mvEn,
    input wire logic        hyst20mvEn,
    input wire logic        hyst10mvEn,
    input wire logic [1:0]  trainSel,
    input wire logic [11:0] customPattern,
    input wire logic        customPatternSel
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_reset_values: assert property ($rose(rst_n) |-> hyst10mvEn && !pllHighBwSel
        && !refClkInvert && customPattern == 12'h000)
        else $error("outputs not at reset values");
    a_pat_sel_on: assert property (ce && trainSel == TRAIN_SEQ_CUSTOM |=> customPatternSel)
        else $error("custom pattern not selected");
    a_pat_sel_off: assert property (ce && trainSel != TRAIN_SEQ_CUSTOM |=> !customPatternSel)
        else $error("custom pattern selected wrongly");
    a_cal_one_cycle: assert property (vcoCalStart |=> !vcoCalStart)
        else $error("calibration start longer than one cycle");
    a_cal_cause: assert property (vcoCalStart |-> !spiCsN || !pllLocked)
        else $error("calibration start without write or lock loss");
    a_oe_idle: assert property (spiCsN [*4] |-> !spiSdoOe)
        else $error("data out driven outside a frame");
    a_oe_rise_frame: assert property ($rose(spiSdoOe) |-> !spiCsN)
        else $error("data out enabled outside a frame");
    a_bw_in_frame: assert property ($changed(pllHighBwSel) |-> !spiCsN)
        else $error("bandwidth select changed without a write");
    a_pat_in_frame: assert property ($changed(customPattern) |-> !spiCsN)
        else $error("pattern changed without a write");

    c_cal: cover property (vcoCalStart);
    c_read: cover property ($rose(spiSdoOe));
    c_pat: cover property (customPatternSel && customPattern != 12'h000);
endmodule

// File: bench/cpr_host.sv
// Host controller model driving frames on the serial control port
`timescale 1ns/1ps
module cpr_host
(
    // Clock
    input  wire logic  clk,
    // Serial port
    output logic       spiCsN,
    output logic       spiSclk,
    output logic       spiSdi,
    input  wire logic  spiSdo,
    input  wire logic  spiSdoOe,
    // Read result
    output logic [7:0] rdData,
    output logic       rdStrobe
);
    // One clock above the minimum phase so data out has settled before sampling
    localparam int PH = 5;

    initial
    begin
        spiCsN = 1'b1;
        spiSclk = 1'b0;
        spiSdi = 1'b0;
        rdData = 8'h00;
        rdStrobe = 1'b0;
    end

    task automatic frame(input logic rd, input logic [6:0] a, input logic [7:0] d,
                         output logic [7:0] q);
        logic [15:0] sh;
        sh = {rd, a, d};
        q = 8'h00;
        spiCsN <= 1'b0;
        for (int i = 15; i >= 0; i--)
        begin
            spiSdi <= sh[i];
            repeat (PH) @(posedge clk);
            if (i < 8)
                q = {q[6:0], spiSdoOe ? spiSdo : 1'b1};  // Undriven line floats to the pull-up level
            spiSclk <= 1'b1;
            repeat (PH) @(posedge clk);
            spiSclk <= 1'b0;
        end
        repeat (PH) @(posedge clk);
        spiCsN <= 1'b1;
        // A released data line must not look like it still holds the last bit
        spiSdi <= ~sh[0];
        rdData <= q;
        rdStrobe <= rd;
        @(posedge clk);
        rdStrobe <= 1'b0;
        repeat (PH - 1) @(posedge clk);
    endtask
endmodule

// File: bench/testbench.sv
// Self-checking bench for the configuration register bank
`timescale 1ns/1ps
module testbench;
    import cpr_pkg::*;
    logic        clk, rst_n, ce, pllLocked, rdStrobe;
    logic        spiCsN, spiSclk, spiSdi, spiSdo, spiSdoOe;
    logic        pllHighBwSel, vcoCalStart, refClkInvert, customPatternSel;
    logic        hyst100mvEn, hyst50mvEn, hyst20mvEn, hyst10mvEn;
    logic [1:0]  trainSel;
    logic [11:0] customPattern;
    logic [7:0]  rdData, d, v;
    logic [7:0]  shadow [4];
    logic [7:0]  expQ [$];
    int          error_cnt = 0, n_checks = 0, cycles = 0, calCnt = 0, c0;
    integer      seed;
    localparam logic [6:0] WR_A [4] = '{ADDR_PLL_CTRL, ADDR_CLK_HYST, ADDR_PAT_LOW, ADDR_PAT_HIGH};
    localparam logic [6:0] RB_A [4] = '{ADDR_PLL_RB, ADDR_CLK_HYST_RB, ADDR_PAT_LOW_RB,
                                        ADDR_PAT_HIGH_RB};
    localparam logic [7:0] MASK [4] = '{8'h03, 8'h3f, 8'hff, 8'h0f};

    cpr_regs u_cpr_regs (.clk(clk), .rst_n(rst_n), .ce(ce), .spiCsN(spiCsN),
        .spiSclk(spiSclk), .spiSdi(spiSdi), .spiSdo(spiSdo), .spiSdoOe(spiSdoOe),
        .pllLocked(pllLocked), .pllHighBwSel(pllHighBwSel), .vcoCalStart(vcoCalStart),
        .refClkInvert(refClkInvert), .hyst100mvEn(hyst100mvEn), .hyst50mvEn(hyst50mvEn),
        .hyst20mvEn(hyst20mvEn), .hyst10mvEn(hyst10mvEn), .trainSel(trainSel),
        .customPattern(customPattern), .customPatternSel(customPatternSel));
    cpr_host u_cpr_host (.clk(clk), .spiCsN(spiCsN), .spiSclk(spiSclk), .spiSdi(spiSdi),
        .spiSdo(spiSdo), .spiSdoOe(spiSdoOe), .rdData(rdData), .rdStrobe(rdStrobe));

    initial clk = 1'b0;
    always #50 clk = ~clk;

    task automatic check(input string nm, input logic [11:0] seen, input logic [11:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] dat);
        logic [7:0] q;
        u_cpr_host.frame(1'b0, a, dat, q);
    endtask

    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        logic [7:0] q;
        expQ.push_back(e);
        u_cpr_host.frame(1'b1, a, 8'h00, q);
    endtask

    always @(posedge clk)
        if (rdStrobe === 1'b1)
            check("readback", 12'(rdData), 12'(expQ.pop_front()));

    always @(posedge clk)
    begin
        trainSel <= 2'($random(seed));
        if (vcoCalStart === 1'b1)
            calCnt <= calCnt + 1;
        cycles <= cycles + 1;
        if (cycles == 40000)
        begin
            error_cnt++;
            wrap_up();
        end
    end

    initial
    begin
        seed = 32'h2d8a_5e9c;
        rst_n = 1'b0;
        ce = 1'b1;
        pllLocked = 1'b1;
        shadow = '{8'h00, 8'h00, 8'h00, 8'h00};
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        check("default hyst", 12'(hyst10mvEn), 12'h001);
        foreach (RB_A[i])
            rd(RB_A[i], 8'h00);
        c0 = calCnt;
        wr(ADDR_PLL_CTRL, 8'h01); // Low bandwidth while the input clock is unsettled
        pllLocked <= 1'b0;
        repeat (10) @(posedge clk);
        pllLocked <= 1'b1;
        wr(ADDR_PLL_CTRL, 8'h00);
        pllLocked <= 1'b0;
        repeat (10) @(posedge clk);
        pllLocked <= 1'b1;
        repeat (10) @(posedge clk);
        check("cal starts", 12'(calCnt - c0), 12'h002);
        for (int i = 0; i < 16; i++)
        begin
            d = 8'($random(seed)) & MASK[i % 4];
            shadow[i % 4] = d;
            wr(WR_A[i % 4], d);
            rd(RB_A[i % 4], d);
            rd(WR_A[i % 4], 8'h00);
            check("pattern", customPattern, {shadow[3][3:0], shadow[2]});
            check("bandwidth", 12'(pllHighBwSel), 12'(shadow[0][1]));
        end
        wr(ADDR_PLL_RB, 8'hff);
        rd(ADDR_PLL_RB, shadow[0]);
        rd(7'h20, 8'h00);
        // A frame sent while the block is frozen must leave no trace
        ce <= 1'b0;
        wr(ADDR_PAT_LOW, ~shadow[2]);
        ce <= 1'b1;
        check("frozen pattern", customPattern, {shadow[3][3:0], shadow[2]});
        for (int i = 0; i < 64; i++)
        begin
            v = 8'(i);
            wr(ADDR_CLK_HYST, v);
            check("clock input", 12'({refClkInvert, hyst100mvEn, hyst50mvEn, hyst20mvEn,
                hyst10mvEn}), 12'({v[5], v[4] & ~v[0], v[3] & ~v[0], v[2] & ~v[0],
                ~v[1] & ~v[0]}));
        end
        rd(ADDR_CLK_HYST_RB, v);
        repeat (4) @(posedge clk);
        check("pending reads", 12'(expQ.size()), 12'h000);
        wrap_up();
    end
endmodule

bind cpr_regs cpr_regs_checker u_cpr_regs_checker (.clk(clk), .rst_n(rst_n), .ce(ce),
    .spiCsN(spiCsN), .spiSdoOe(spiSdoOe), .pllLocked(pllLocked), .pllHighBwSel(pllHighBwSel),
    .vcoCalStart(vcoCalStart), .refClkInvert(refClkInvert), .hyst100mvEn(hyst100mvEn),
    .hyst50mvEn(hyst50mvEn), .hyst20mvEn(hyst20mvEn), .hyst10mvEn(hyst10mvEn),
    .trainSel(trainSel), .customPattern(customPattern), .customPatternSel(customPatternSel));
